/* File: design/tcap_timer.sv */
// dual reload/capture timer with AHB-Lite register access
// assumes async pins on timerPinA/B, 100 MHz clk, one bus master
//
// Summary of operation
// - 16-bit timer plus reload/capture registers A, B
// - PWM mode counts down each instruction tick
// - PWM underflow reloads; first reload from A
// - then alternate reloads B, A, B...
// - mode 101 toggles pin A; 100 not
// - PWM reload A sets pend A, B sets B
// - enables A/B request interrupts for their reloads
// - enable 1 allows, 0 suppresses interrupt
// - run bit starts/stops PWM and event modes
// - event mode counts pin A edges, underflow pends A
// - event mode counts positive pin A edges
// - event mode pin B rise sets pend B
// - no PWM output in event mode
// - capture mode counts every instruction tick
// - pin triggers copy timer into A or B
// - capture edges per pin from mode bits
// - capture triggers set pend A/B, gated interrupts
// - capture underflow sets run bit, gated by A
// - mode and run at control bits 7..4
// - pend/enable B bits 1..0; A in status
// - timer and A/B registers not reset
//
// The AHB-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module tcap_timer
    import tcap_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic [2:0]  hsize,
    input  wire logic        hwrite,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        timerPinAIn,
    output logic             timerPinAOut,
    output logic             timerPinAOe,
    input  wire logic        timerPinBIn,
    output logic             irqA,
    output logic             irqB
);
    import tcap_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    tcap_mode_type       mode_q;
    logic                run_q;
    logic                pendA_q;
    logic                enA_q;
    logic                pendB_q;
    logic                enB_q;
    logic [TIMER_W-1:0]  timer_q;
    logic [TIMER_W-1:0]  regA_q;
    logic [TIMER_W-1:0]  regB_q;
    logic                selB_q;
    logic [TICK_W-1:0]   tickCnt_q;
    logic                tick_q;
    logic                pinAOut_q;
    logic                pinAOe_q;
    logic                irqA_q;
    logic                irqB_q;
    logic [31:0]         hrdata_q;
    logic [31:0]         rdVal;

    logic aRise, aFall, bRise, bFall;
    logic isPwm, isEvent, isCap;
    logic wrCtrl, wrPsw, wrIctrl, wrTimer, wrRegA, wrRegB;
    logic runStart, dec, underflow, capA, capB, reloadA, reloadB;
    logic run_d, pendA_d, pendB_d;

    tcap_regbus_if bus ();

    tcap_ahb_bridge u_bridge (
        .clk    (clk),
        .rst_n  (rst_n),
        .hsel   (hsel),
        .haddr  (haddr),
        .htrans (htrans),
        .hwrite (hwrite),
        .hready (hready),
        .hwdata (hwdata),
        .bus    (bus.bridge)
    );

    // ----------------------------------------
    // pin edges
    // ----------------------------------------
    tcap_pin_sync u_syncA (
        .clk   (clk),
        .rst_n (rst_n),
        .pin   (timerPinAIn),
        .rise  (aRise),
        .fall  (aFall)
    );

    tcap_pin_sync u_syncB (
        .clk   (clk),
        .rst_n (rst_n),
        .pin   (timerPinBIn),
        .rise  (bRise),
        .fall  (bFall)
    );

    // ----------------------------------------
    // instruction cycle tick
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tickCnt_q <= '0;
            tick_q    <= 1'b0;
        end else begin
            tickCnt_q <= (tickCnt_q == TICK_LAST) ? '0 : tickCnt_q + 1'b1;
            tick_q    <= (tickCnt_q == TICK_LAST);
        end
    end

    // ----------------------------------------
    // decode
    // ----------------------------------------
    assign isPwm   = mode_q[2] & ~mode_q[1];
    assign isEvent = ~mode_q[2] & ~mode_q[1];
    assign isCap   = mode_q[1];

    assign wrCtrl  = bus.wrEn && (bus.wrIdx == IDX_CTRL);
    assign wrPsw   = bus.wrEn && (bus.wrIdx == IDX_PSW);
    assign wrIctrl = bus.wrEn && (bus.wrIdx == IDX_ICTRL);
    assign wrTimer = bus.wrEn && (bus.wrIdx == IDX_TIMER);
    assign wrRegA  = bus.wrEn && (bus.wrIdx == IDX_REGA);
    assign wrRegB  = bus.wrEn && (bus.wrIdx == IDX_REGB);

    assign runStart = wrCtrl & bus.wrData[CTRL_RUN] & ~run_q;

    assign dec = (isPwm & run_q & tick_q)
               | (isEvent & run_q & aRise)
               | (isCap & tick_q);
    assign underflow = dec & (timer_q == TIMER_ZERO);
    assign reloadA   = isPwm & underflow & ~selB_q;
    assign reloadB   = isPwm & underflow & selB_q;

    // 010/110 catch A on rise, 011/111 on fall; B rises only in 010
    assign capA = isCap & (mode_q[0] ? aFall : aRise);
    assign capB = isCap & ((mode_q == MODE_CAP_PP) ? bRise : bFall);

    // ----------------------------------------
    // timer and reload/capture registers, no reset on purpose
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (wrTimer) begin
            timer_q <= bus.wrData[TIMER_W-1:0];
        end else if (reloadA || (isEvent && underflow)) begin
            timer_q <= regA_q;
        end else if (reloadB) begin
            timer_q <= regB_q;
        end else if (dec) begin
            timer_q <= timer_q - TIMER_ONE; // holds when no dec
        end
    end

    always_ff @(posedge clk) begin
        if (capA) begin
            regA_q <= timer_q;
        end else if (wrRegA) begin
            regA_q <= bus.wrData[TIMER_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (capB) begin
            regB_q <= timer_q;
        end else if (wrRegB) begin
            regB_q <= bus.wrData[TIMER_W-1:0];
        end
    end

    // ----------------------------------------
    // reload alternation
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            selB_q <= 1'b0;
        end else if (runStart) begin
            selB_q <= 1'b0;
        end else if (isPwm && underflow) begin
            selB_q <= ~selB_q;
        end
    end

    // ----------------------------------------
    // control and flag bits; hardware set beats software clear
    // ----------------------------------------
    assign run_d   = (wrCtrl ? bus.wrData[CTRL_RUN] : run_q)
                   | (isCap & underflow);
    assign pendA_d = (wrPsw ? bus.wrData[PSW_PEND_A] : pendA_q)
                   | reloadA | (isEvent & underflow) | capA;
    assign pendB_d = (wrIctrl ? bus.wrData[ICTRL_PEND_B] : pendB_q)
                   | reloadB | (isEvent & bRise) | capB;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= MODE_RESET;
            run_q  <= 1'b0;
        end else begin
            if (wrCtrl) begin
                mode_q <= bus.wrData[CTRL_MODE_HI:CTRL_MODE_LO];
            end
            run_q <= run_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pendA_q <= 1'b0;
            enA_q   <= 1'b0;
            pendB_q <= 1'b0;
            enB_q   <= 1'b0;
        end else begin
            pendA_q <= pendA_d;
            pendB_q <= pendB_d;
            if (wrPsw) begin
                enA_q <= bus.wrData[PSW_EN_A];
            end
            if (wrIctrl) begin
                enB_q <= bus.wrData[ICTRL_EN_B];
            end
        end
    end

    // ----------------------------------------
    // interrupt requests, levels
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqA_q <= 1'b0;
            irqB_q <= 1'b0;
        end else begin
            // in capture mode the run bit doubles as underflow pending
            irqA_q <= enA_q & (pendA_q | (isCap & run_q));
            irqB_q <= enB_q & pendB_q;
        end
    end

    // ----------------------------------------
    // pin A drive
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pinAOut_q <= 1'b0;
            pinAOe_q  <= 1'b0;
        end else begin
            pinAOe_q <= isPwm; // pin A is an input otherwise
            if (isPwm && underflow && (mode_q == MODE_PWM_TOGGLE)) begin
                pinAOut_q <= ~pinAOut_q; // level held between
            end
        end
    end

    // ----------------------------------------
    // register read, sampled in the address phase
    // ----------------------------------------
    always_comb begin
        rdVal = RD_ZERO;
        unique case (bus.rdIdx)
            IDX_CTRL: begin
                rdVal[CTRL_MODE_HI:CTRL_MODE_LO] = mode_q;
                rdVal[CTRL_RUN]                  = run_q;
            end
            IDX_PSW: begin
                rdVal[PSW_PEND_A] = pendA_q;
                rdVal[PSW_EN_A]   = enA_q;
            end
            IDX_ICTRL: begin
                rdVal[ICTRL_PEND_B] = pendB_q;
                rdVal[ICTRL_EN_B]   = enB_q;
            end
            IDX_TIMER: rdVal[TIMER_W-1:0] = timer_q;
            IDX_REGA:  rdVal[TIMER_W-1:0] = regA_q;
            IDX_REGB:  rdVal[TIMER_W-1:0] = regB_q;
            default:   rdVal = RD_ZERO;
        endcase
    end

    // a read right after a write sees the value before that write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata_q <= RD_ZERO;
        end else begin
            hrdata_q <= bus.rdEn ? rdVal : RD_ZERO;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    assign hrdata       = hrdata_q;
    assign timerPinAOut = pinAOut_q;
    assign timerPinAOe  = pinAOe_q;
    assign irqA         = irqA_q;
    assign irqB         = irqB_q;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // unreset timer: the hold check waits for its first write
    logic timerSet_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timerSet_q <= 1'b0;
        end else begin
            timerSet_q <= timerSet_q | wrTimer;
        end
    end
    a_reload_from_a: assert property (reloadA && !wrTimer |=> timer_q == $past(regA_q))
        else $error("pwm reload did not load register A");
    a_alternate_to_b: assert property (reloadA && !runStart |=> selB_q)
        else $error("reload after A is not from B");
    a_run_start_a: assert property (runStart ##1 isPwm |-> !selB_q)
        else $error("first reload after start is not from A");
    a_toggle_pin: assert property (isPwm && underflow && mode_q == MODE_PWM_TOGGLE
        |=> pinAOut_q != $past(pinAOut_q))
        else $error("pin A did not toggle on underflow");
    a_no_toggle: assert property (mode_q != MODE_PWM_TOGGLE |=> $stable(pinAOut_q))
        else $error("pin A changed outside toggle mode");
    a_pend_a_set: assert property (reloadA |=> pendA_q)
        else $error("pend A not set on reload from A");
    a_irq_a_gate: assert property (!enA_q |=> !irqA_q)
        else $error("interrupt A raised while disabled");
    a_irq_b_raise: assert property (pendB_q && enB_q |=> irqB_q)
        else $error("interrupt B not raised");
    a_event_count: assert property (isEvent && run_q && aRise && timer_q != TIMER_ZERO
        && !wrTimer |=> timer_q == $past(timer_q) - TIMER_ONE)
        else $error("event edge did not decrement timer");
    a_stopped_holds: assert property (timerSet_q && !isCap && !run_q && !wrTimer && !wrCtrl
        |=> $stable(timer_q))
        else $error("stopped timer changed");
    a_pin_b_event: assert property (isEvent && bRise |=> pendB_q)
        else $error("pin B edge did not set pend B");
    a_pin_a_idle: assert property (isEvent |=> !timerPinAOe)
        else $error("pin A driven in event mode");
    a_capture_a: assert property (capA |=> regA_q == $past(timer_q))
        else $error("capture A lost timer value");
    a_cap_uflow: assert property (isCap && underflow |=> run_q ##1 (irqA_q == enA_q))
        else $error("capture underflow not flagged");

    c_pwm_b: cover property (reloadA ##[1:1000] reloadB);
    c_event_uflow: cover property (isEvent && underflow);
    c_capture_b: cover property (capB ##1 pendB_q);
    c_bus_read: cover property (bus.rdEn && bus.rdIdx == IDX_TIMER);

endmodule : tcap_timer

/* File: inc/tcap_pkg.sv */
// constants, register map and mode codes of the dual reload/capture timer
// assumes a 100 MHz core clock and a 32-bit AHB-Lite register bus
package tcap_pkg;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS  = 10;
    localparam int TICK_PERIOD_NS = 1000;
    localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TICK_W         = 7;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int TIMER_W = 16;
    localparam int IDX_W   = 8;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 9;

    // ----------------------------------------
    // register indices (byte address is four times the index)
    // ----------------------------------------
    localparam logic [IDX_W-1:0] IDX_CTRL  = 8'hEE;
    localparam logic [IDX_W-1:0] IDX_PSW   = 8'hEF;
    localparam logic [IDX_W-1:0] IDX_ICTRL = 8'hE8;
    localparam logic [IDX_W-1:0] IDX_TIMER = 8'hE0;
    localparam logic [IDX_W-1:0] IDX_REGA  = 8'hE2;
    localparam logic [IDX_W-1:0] IDX_REGB  = 8'hE4;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CTRL_MODE_HI  = 7;
    localparam int CTRL_MODE_LO  = 5;
    localparam int CTRL_RUN      = 4;
    localparam int PSW_PEND_A    = 5;
    localparam int PSW_EN_A      = 4;
    localparam int ICTRL_PEND_B  = 1;
    localparam int ICTRL_EN_B    = 0;

    // ----------------------------------------
    // modes {mode_bit_hi, mode_bit_mid, mode_bit_lo}
    // ----------------------------------------
    typedef logic [2:0] tcap_mode_type;
    localparam tcap_mode_type MODE_RESET      = 3'h0;
    localparam tcap_mode_type MODE_PWM_TOGGLE = 3'h5;
    localparam tcap_mode_type MODE_CAP_PP     = 3'h2;

    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [31:0] RD_ZERO       = 32'h0000_0000;
    localparam logic [15:0] TIMER_ONE     = 16'h0001;
    localparam logic [15:0] TIMER_ZERO    = 16'h0000;

endpackage : tcap_pkg

/* File: inc/tcap_regbus_if.sv */
// write and read strobes between the bus bridge and the timer core
// assumes both ends share one clock
`timescale 1ns/1ps
interface tcap_regbus_if;
    import tcap_pkg::*;
    logic             wrEn;
    logic [IDX_W-1:0] wrIdx;
    logic [31:0]      wrData;
    logic             rdEn;
    logic [IDX_W-1:0] rdIdx;
    modport bridge (output wrEn, output wrIdx, output wrData, output rdEn, output rdIdx);
    modport core   (input wrEn, input wrIdx, input wrData, input rdEn, input rdIdx);
endinterface : tcap_regbus_if

/* File: design/tcap_pin_sync.sv */
// three-stage pin synchroniser with rise and fall pulses
// assumes an asynchronous pin; pulses last one clock
`timescale 1ns/1ps
module tcap_pin_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pin,
    output logic      rise,
    output logic      fall
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // only stages two and three judge the edge
    assign rise = s2_q & ~s3_q;
    assign fall = ~s2_q & s3_q;
endmodule : tcap_pin_sync

/* File: design/tcap_ahb_bridge.sv */
// AHB-Lite slave front end: zero wait states, word transfers only
// assumes a single slave, hready fed back from hreadyout
`timescale 1ns/1ps
module tcap_ahb_bridge
    import tcap_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    tcap_regbus_if.bridge    bus
);
    logic             take;
    logic             wrPend_q;
    logic [IDX_W-1:0] wrIdx_q;

    // addresses above the index field are unmapped
    assign take = hsel & hready & htrans[1] & (haddr[31:IDX_MSB+1] == '0);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPend_q <= 1'b0;
            wrIdx_q  <= '0;
        end else begin
            wrPend_q <= take & hwrite;
            if (take) begin
                wrIdx_q <= haddr[IDX_MSB:IDX_LSB];
            end
        end
    end

    assign bus.wrEn   = wrPend_q;
    assign bus.wrIdx  = wrIdx_q;
    assign bus.wrData = hwdata;
    assign bus.rdEn   = take & ~hwrite;
    assign bus.rdIdx  = haddr[IDX_MSB:IDX_LSB];
endmodule : tcap_ahb_bridge

/* File: verification/tcap_pin_src.sv */
// pin-side source model: drives timer pins A and B as plain levels
// assumes the bench calls setA/setB just after a rising clock edge
`timescale 1ns/1ps
module tcap_pin_src (
    input  wire logic aOut,
    input  wire logic aOe,
    output logic      pinA,
    output logic      pinB
);
    logic aDrv;
    logic bDrv;

    initial begin
        aDrv = 1'b0;
        bDrv = 1'b0;
    end

    // pin A is shared: the block owns the wire while it enables its driver
    assign pinA = aOe ? aOut : aDrv;
    assign pinB = bDrv;

    task automatic setA(input logic v);
        aDrv <= v;
    endtask : setA

    task automatic setB(input logic v);
        bDrv <= v;
    endtask : setB
endmodule : tcap_pin_src

/* File: verification/tb_tcap_timer.sv */
// self-checking bench for the dual reload/capture timer
// assumes zero-wait AHB-Lite slave and a pin source model on pins A/B
`timescale 1ns/1ps
module tb_tcap_timer;
    import tcap_pkg::*;
    logic        clk;
    logic        rst_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hresp;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hready;
    logic        pinA;
    logic        pinB;
    logic        pinAOut;
    logic        pinAOe;
    logic        irqA;
    logic        irqB;
    int          n_fail;
    int          tests_run;

    tcap_timer u_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hsize(hsize), .hwrite(hwrite), .hready(hready),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
        .timerPinAIn(pinA), .timerPinAOut(pinAOut), .timerPinAOe(pinAOe),
        .timerPinBIn(pinB), .irqA(irqA), .irqB(irqB));
    tcap_pin_src u_src (.aOut(pinAOut), .aOe(pinAOe), .pinA(pinA), .pinB(pinB));

    always #5 clk = ~clk;

    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t %s seen %h expected %h", $time, m, seen, exp);
        end
    endtask : chk

    // ----------------------------------------
    // bus master: hready and read data taken at the rising edge
    // ----------------------------------------
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {22'h00_0000, idx, 2'b00};
        htrans <= HTRANS_NONSEQ;
        hsize  <= 3'h2;
        hwrite <= w;
        do begin
            @(posedge clk);
        end while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge clk);
        end while (hready !== 1'b1);
        rd = hrdata;
        // idle edge so a following call never re-raises hsel in this time step
        hsel <= 1'b0;
        @(posedge clk);
    endtask : xfer

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] x;
        xfer(1'b1, idx, d, x);
    endtask : wr

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] e, input string m);
        logic [31:0] x;
        xfer(1'b0, idx, 32'h0000_0000, x);
        chk(x, e, m);
        chk(hresp, 1'b0, "resp okay");
    endtask : rdchk

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    // 0 irqA, 1 irqB, 2 pin A output high; bounded so a dead timer cannot hang
    task automatic waitSig(input int s, input int lim);
        int n;
        n = 0;
        while (!(s == 0 ? irqA === 1'b1 : s == 1 ? irqB === 1'b1 : pinAOut === 1'b1)
               && n < lim) begin
            @(posedge clk);
            n++;
        end
        chk(n < lim, 1'b1, "wait");
    endtask : waitSig

    task automatic pulseA;
        u_src.setA(1'b1); idle(6);
        u_src.setA(1'b0); idle(6);
    endtask : pulseA

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic testRegs;
        rdchk(IDX_CTRL, 32'h0000_0000, "ctrl rst");
        rdchk(IDX_PSW, 32'h0000_0000, "psw rst");
        wr(8'h00, 32'hFFFF_FFFF);
        rdchk(8'h00, 32'h0000_0000, "unmapped");
        wr(IDX_TIMER, 32'hFFFF_1234);
        rdchk(IDX_TIMER, 32'h0000_1234, "timer width");
        $display("test regs done");
    endtask : testRegs

    task automatic testPwm;
        logic [31:0] t0;
        logic        p;
        wr(IDX_REGA, 32'h0000_0002);
        wr(IDX_REGB, 32'h0000_0001);
        wr(IDX_TIMER, 32'h0000_0000);
        wr(IDX_PSW, 32'h0000_0010);
        wr(IDX_ICTRL, 32'h0000_0001);
        wr(IDX_CTRL, 32'h0000_00B0);
        waitSig(0, 250);
        chk(pinAOut, 1'b1, "toggle a");
        chk(irqB, 1'b0, "irqB early");
        rdchk(IDX_PSW, 32'h0000_0030, "pend a");
        waitSig(1, 400);
        chk(pinAOut, 1'b0, "toggle b");
        rdchk(IDX_ICTRL, 32'h0000_0003, "pend b");
        wr(IDX_PSW, 32'h0000_0000);
        waitSig(2, 400);
        idle(3);
        chk(irqA, 1'b0, "irqA masked");
        rdchk(IDX_PSW, 32'h0000_0020, "pend a masked");
        rdchk(IDX_ICTRL, 32'h0000_0003, "pend b kept");
        wr(IDX_CTRL, 32'h0000_00A0);
        p = pinAOut;
        xfer(1'b0, IDX_TIMER, 32'h0000_0000, t0);
        idle(250);
        rdchk(IDX_TIMER, t0, "stopped");
        chk(pinAOut, p, "pin held");
        wr(IDX_ICTRL, 32'h0000_0001);
        wr(IDX_CTRL, 32'h0000_0090);
        waitSig(1, 800);
        chk(pinAOut, p, "no toggle");
        $display("test pwm done");
    endtask : testPwm

    task automatic testEvent;
        u_src.setA(1'b0);
        u_src.setB(1'b0);
        wr(IDX_CTRL, 32'h0000_0010);
        wr(IDX_TIMER, 32'h0000_0002);
        wr(IDX_PSW, 32'h0000_0010);
        wr(IDX_ICTRL, 32'h0000_0001);
        chk(pinAOe, 1'b0, "no pwm out");
        pulseA();
        pulseA();
        rdchk(IDX_TIMER, 32'h0000_0000, "edge count");
        chk(irqA, 1'b0, "no underflow");
        pulseA();
        rdchk(IDX_PSW, 32'h0000_0030, "ev pend a");
        chk(irqA, 1'b1, "ev irqA");
        u_src.setB(1'b1);
        idle(8);
        rdchk(IDX_ICTRL, 32'h0000_0003, "ev pend b");
        chk(irqB, 1'b1, "ev irqB");
        $display("test event done");
    endtask : testEvent

    task automatic testCapture;
        tcap_mode_type md[4] = '{3'h2, 3'h6, 3'h3, 3'h7};
        logic [31:0]   r;
        logic          sA;
        logic          sB;
        foreach (md[i]) begin
            sA = md[i][0];
            sB = (md[i] != MODE_CAP_PP);
            u_src.setA(sA);
            u_src.setB(sB);
            idle(8);
            wr(IDX_CTRL, {24'h00_0000, md[i], 5'h00});
            wr(IDX_TIMER, 32'h0000_1000);
            wr(IDX_PSW, 32'h0000_0010);
            wr(IDX_ICTRL, 32'h0000_0001);
            u_src.setA(!sA);
            u_src.setB(!sB);
            idle(8);
            rdchk(IDX_PSW, 32'h0000_0030, "cap pend a");
            rdchk(IDX_ICTRL, 32'h0000_0003, "cap pend b");
            chk({irqA, irqB}, 2'b11, "cap irq");
            xfer(1'b0, IDX_REGA, 32'h0000_0000, r);
            chk(r === 32'h0000_1000 || r === 32'h0000_0FFF, 1'b1, "cap a");
            xfer(1'b0, IDX_REGB, 32'h0000_0000, r);
            chk(r === 32'h0000_1000 || r === 32'h0000_0FFF, 1'b1, "cap b");
        end
        wr(IDX_CTRL, 32'h0000_0040);
        wr(IDX_PSW, 32'h0000_0010);
        wr(IDX_TIMER, 32'h0000_0000);
        waitSig(0, 250);
        rdchk(IDX_CTRL, 32'h0000_0050, "underflow run");
        rdchk(IDX_PSW, 32'h0000_0010, "no capture");
        $display("test capture done");
    endtask : testCapture

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hsize = 3'h0;
        hwrite = 1'b0;
        hwdata = 32'h0000_0000;
        n_fail = 0;
        tests_run = 0;
        idle(4);
        rst_n <= 1'b1;
        @(posedge clk);
        testRegs();
        testPwm();
        testEvent();
        testCapture();
        conclude();
    end

    // whole run is a few thousand cycles; allow generous slack
    initial begin
        #200000;
        n_fail++;
        conclude();
    end
endmodule : tb_tcap_timer
